// file: hdl/uart_enh_regs.sv
// Purpose: Enhanced-feature registers and small control logic of one channel.
// Assumes: Counts, strobes and bit ticks come from the channel core on clk_i.
// Notes: Peer ports link the two channels for concurrent writes.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Basic hysteresis codes give 0, 4, 6, 8.
// - Extended codes select the other hysteresis rows.
// - Basic hysteresis field clears on reset.
// - Delayed mode: error interrupt at holding register.
// - Immediate mode: error interrupt on FIFO entry.
// - Sampling bit: 0 is 8x, 1 16x default.
// - Swap bit redirects scratchpad reads and writes.
// - Divisor is integer latches plus fraction/16.
// - Fraction latch accessible only with enhanced enable.
// - Concurrent write updates both channels' register unless the peer has a local write that cycle.
// - Reads return only the selected channel's data.
// - Output select picks out2, baud or ready.
// - Upper alternate function bits reserved, zero.
// - Read-only identity and revision registers.
// - Trigger register programs receive or transmit level.
// - Count register readable when line control 0xbf.
// - Inversion bit selects receive idle polarity.
// - Direction rises one bit after last stop.
// - Direction drops on FIFO load; interrupt timing.
// - Table select chooses table A to D.
// - Level readback picks receive, transmit or alternates.
// - Inversion bit flips direction output polarity.
// - Auto flow output follows trigger plus hysteresis.
// - Clearing enhanced enable freezes the fraction.
module uart_enh_regs
   import uart_enh_pkg::*;
#(
   parameter int CNT_W = 7,
   parameter logic [7:0] DEV_ID_VAL = 8'h5c,  // Arbitrary value.
   parameter logic [7:0] DEV_REV_VAL = 8'h03  // Arbitrary value.
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Peer channel write link.
   input wire logic peer_we_i,
   input wire logic [7:0] peer_adr_i,
   input wire logic [7:0] peer_dat_i,
   output logic peer_we_o,
   output logic [7:0] peer_adr_o,
   output logic [7:0] peer_dat_o,
   // Channel core status.
   input wire logic [CNT_W-1:0] rx_count_i,
   input wire logic [CNT_W-1:0] tx_count_i,
   input wire logic [7:0] rx_table_level_i,
   input wire logic err_into_fifo_i,
   input wire logic err_at_holding_i,
   input wire logic status_read_i,
   input wire logic tx_fifo_load_i,
   input wire logic tx_shift_done_i,
   input wire logic thr_empty_i,
   input wire logic tsr_empty_i,
   input wire logic bit_tick_i,
   input wire logic auto_rts_en_i,
   input wire logic rts_manual_n_i,
   input wire logic user_output_two_i,
   input wire logic baud_clock_i,
   input wire logic receive_ready_i,
   input wire logic rx_pin_i,
   // Configuration to the channel core.
   output logic [15:0] div_int_o,
   output logic [3:0] div_frac_o,
   output logic sample16_o,
   output logic [1:0] trig_table_o,
   output logic [7:0] rx_trig_o,
   output logic [7:0] tx_trig_o,
   // Derived outputs.
   output logic line_irq_o,
   output logic tx_irq_o,
   output logic rts_n_o,
   output logic multi_function_out_o,
   output logic rx_data_o
);
   if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
      $error("CNT_W must lie between 1 and 8");
   end

   typedef struct packed {
      logic ack;
      logic [7:0] rdat;
      logic [7:0] dll;
      logic [7:0] divisor_high_byte;
      logic [7:0] divisor_fraction;
      logic cw;
      logic [1:0] mf_sel;
      logic [7:0] feature_control;
      logic [7:0] emode;
      logic [7:0] trg_rx;
      logic [7:0] trg_tx;
      logic [7:0] line_control;
      logic enh;
      logic [7:0] scratch;
      logic alt_tx;
      logic lsr_pend;
      logic line_irq;
      logic tx_irq;
      logic dir_tx;
      logic wait485;
      logic flow_stop;
      logic rts_n;
      logic mf;
      logic pwe;
      logic [7:0] padr;
      logic [7:0] pdat;
      logic [2:0] rx_sync;
      logic rx_filt;
   } state_s;

   state_s q, d;

   function automatic logic [7:0] cnt8(input logic [CNT_W-1:0] c);
      cnt8 = 8'(c);
   endfunction : cnt8

   logic req;
   logic wr_local;
   logic [7:0] wdat;
   logic [5:0] hyst;
   logic [8:0] upper;
   logic [8:0] lower;
   logic [7:0] rx_trig_eff;

   assign req = cyc_i && stb_i && !q.ack;
   assign wr_local = req && we_i && sel_i[0];
   assign wdat = dat_i[7:0];
   assign hyst = HYST_TAB[{q.emode[EM_XHYS+:2], q.feature_control[FT_HYS+:2]}];
   assign rx_trig_eff = (q.feature_control[FT_TBL+:2] == TBL_D) ? q.trg_rx
                                                      : rx_table_level_i;
   assign upper = {1'b0, rx_trig_eff} + {3'h0, hyst};
   assign lower = {1'b0, rx_trig_eff} - {3'h0, hyst};

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      logic wr;
      logic [7:0] wa;
      logic [7:0] wd;
      logic full;
      d = q;
      wr = 1'b0;
      wa = 8'h00;
      wd = 8'h00;
      full = 1'b1;
      d.ack = req;
      d.pwe = 1'b0;
      if (wr_local) begin
         wr = 1'b1;
         wa = adr_i;
         wd = wdat;
         if (q.cw || adr_i == ADR_ALT_FN) begin
            d.pwe = 1'b1;
            d.padr = adr_i;
            d.pdat = wdat;
         end
      end else if (peer_we_i) begin
         // A peer write lands only when no local write competes; the peer
         // drives its strobe from a register, so a lost one is rare.
         wr = 1'b1;
         wa = peer_adr_i;
         wd = peer_dat_i;
         full = (peer_adr_i != ADR_ALT_FN) || q.cw
                || peer_dat_i[AF_CW];
      end
      if (wr) begin
         unique case (wa)
            ADR_DIV_LO: if (full) d.dll = wd;
            ADR_DIV_HI: if (full) d.divisor_high_byte = wd;
            ADR_DIV_FR: if (full && q.enh) d.divisor_fraction = wd;
            ADR_ALT_FN: begin
               d.cw = wd[AF_CW];
               if (full && wd[AF_MF+:2] != MF_RSVD) begin
                  d.mf_sel = wd[AF_MF+:2];
               end
            end
            ADR_TRG: if (full) begin
               if (q.feature_control[FT_TSEL]) d.trg_tx = wd;
               else d.trg_rx = wd;
            end
            ADR_FEAT: if (full) d.feature_control = wd;
            ADR_SCRATCH: if (full) begin
               if (q.feature_control[FT_SWAP]) begin
                  d.emode = wd & EMODE_WMASK;
                  d.alt_tx = 1'b0;
               end else begin
                  d.scratch = wd;
               end
            end
            ADR_ENH_FEAT: if (full) d.enh = wd[ENH_BIT];
            ADR_LINE_CTL: if (full) d.line_control = wd;
            default: ;
         endcase
      end
      // Read data is always from this channel's own registers.
      d.rdat = 8'h00;
      if (req && !we_i) begin
         unique case (adr_i)
            ADR_DIV_LO: d.rdat = q.dll;
            ADR_DIV_HI: d.rdat = q.divisor_high_byte;
            ADR_DIV_FR: d.rdat = q.enh ? q.divisor_fraction : 8'h00;
            ADR_ALT_FN: d.rdat = {5'h00, q.mf_sel, q.cw};
            ADR_DEV_ID: d.rdat = DEV_ID_VAL;
            ADR_DEV_RV: d.rdat = DEV_REV_VAL;
            ADR_FCOUNT: if (q.line_control == FC_KEY) begin
               d.rdat = q.feature_control[FT_TSEL] ? cnt8(tx_count_i) : cnt8(rx_count_i);
            end
            ADR_FEAT: d.rdat = q.feature_control;
            ADR_SCRATCH: begin
               if (!q.feature_control[FT_SWAP]) begin
                  d.rdat = q.scratch;
               end else if (!q.emode[EM_CNT]) begin
                  d.rdat = cnt8(rx_count_i);
               end else if (!q.emode[EM_CNT+1]) begin
                  d.rdat = cnt8(tx_count_i);
               end else begin
                  d.rdat = q.alt_tx ? cnt8(tx_count_i) : cnt8(rx_count_i);
                  d.alt_tx = !q.alt_tx;
               end
            end
            ADR_ENH_FEAT: d.rdat = {3'h0, q.enh, 4'h0};
            ADR_LINE_CTL: d.rdat = q.line_control;
            default: d.rdat = 8'h00;
         endcase
      end
      // A new error entering the FIFO wins over a status read clearing it.
      if (err_into_fifo_i) begin
         d.lsr_pend = 1'b1;
      end else if (status_read_i) begin
         d.lsr_pend = 1'b0;
      end
      d.line_irq = q.emode[EM_LSRI] ? d.lsr_pend : err_at_holding_i;
      d.tx_irq = q.feature_control[FT_R485] ? (thr_empty_i && tsr_empty_i)
                                 : thr_empty_i;
      // Direction: a byte loaded while waiting cancels the release.
      if (tx_fifo_load_i) begin
         d.dir_tx = 1'b1;
         d.wait485 = 1'b0;
      end else if (q.wait485 && bit_tick_i) begin
         d.dir_tx = 1'b0;
         d.wait485 = 1'b0;
      end else if (tx_shift_done_i && q.dir_tx) begin
         d.wait485 = 1'b1;
      end
      if ({1'b0, cnt8(rx_count_i)} >= upper) begin
         d.flow_stop = 1'b1;
      end else if ({1'b0, rx_trig_eff} < {3'h0, hyst} ||
                   {1'b0, cnt8(rx_count_i)} < lower) begin
         d.flow_stop = 1'b0;
      end
      if (q.feature_control[FT_R485]) begin
         d.rts_n = !d.dir_tx ^ q.emode[EM_INV];
      end else if (auto_rts_en_i) begin
         d.rts_n = d.flow_stop || rts_manual_n_i;
      end else begin
         d.rts_n = rts_manual_n_i;
      end
      unique case (q.mf_sel)
         MF_OUT2: d.mf = user_output_two_i;
         MF_BAUD: d.mf = baud_clock_i;
         MF_RECEIVE_READY_OUT: d.mf = receive_ready_i;
         default: d.mf = 1'b1;
      endcase
      // Stages two and three must agree; the third supplies the data; the first feeds the second alone.
      d.rx_sync = {q.rx_sync[1:0], rx_pin_i};
      if (q.rx_sync[1] == q.rx_sync[2]) begin
         d.rx_filt = q.rx_sync[2] ^ q.feature_control[FT_IRINV];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.dll <= DIV_LO_RST;
         q.divisor_high_byte <= DIV_HI_RST;
         q.emode <= EMODE_RST;
         q.scratch <= SCRATCH_RST;
         q.rts_n <= 1'b1;
         q.mf <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign dat_o = {24'h000000, q.rdat};
   assign ack_o = q.ack;
   assign peer_we_o = q.pwe;
   assign peer_adr_o = q.padr;
   assign peer_dat_o = q.pdat;
   assign div_int_o = {q.divisor_high_byte, q.dll};
   assign div_frac_o = q.divisor_fraction[3:0];
   assign sample16_o = q.emode[EM_S16];
   assign trig_table_o = q.feature_control[FT_TBL+:2];
   assign rx_trig_o = q.trg_rx;
   assign tx_trig_o = q.trg_tx;
   assign line_irq_o = q.line_irq;
   assign tx_irq_o = q.tx_irq;
   assign rts_n_o = q.rts_n;
   assign multi_function_out_o = q.mf;
   assign rx_data_o = q.rx_filt;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_done_wait;
      tx_shift_done_i && q.dir_tx && !tx_fifo_load_i;
   endsequence
   sequence s_tick_no_load;
      bit_tick_i && !tx_fifo_load_i;
   endsequence

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held two cycles");
   a_frac_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.enh && !$past(rst_i) |=> $stable(div_frac_o))
      else $error("fraction changed while locked");
   a_lsr_delayed: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.emode[EM_LSRI] |=> line_irq_o == $past(err_at_holding_i))
      else $error("delayed line interrupt wrong");
   a_lsr_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
      q.emode[EM_LSRI] && err_into_fifo_i ##1 q.emode[EM_LSRI] |-> line_irq_o)
      else $error("immediate line interrupt missing");
   a_rs485_release: assert property (@(posedge clk_i) disable iff (rst_i)
      q.feature_control[FT_R485] && !q.emode[EM_INV] ##0 s_done_wait ##1
      (!tx_fifo_load_i && !bit_tick_i)[*1] ##1 s_tick_no_load
      |=> q.feature_control[FT_R485] |-> rts_n_o)
      else $error("direction not released after bit time");
   a_rs485_load: assert property (@(posedge clk_i) disable iff (rst_i)
      q.feature_control[FT_R485] && !q.emode[EM_INV] && tx_fifo_load_i
      |=> q.feature_control[FT_R485] |-> !rts_n_o) else $error("direction not driven");
   a_mf_baud: assert property (@(posedge clk_i) disable iff (rst_i)
      q.mf_sel == MF_BAUD |=> multi_function_out_o == $past(baud_clock_i))
      else $error("multi function output wrong");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o && $past(adr_i) == ADR_ALT_FN && !$past(we_i)
      |-> dat_o[7:3] == 5'h00) else $error("reserved bits read nonzero");
   a_hyst_basic: assert property (@(posedge clk_i) disable iff (rst_i)
      q.emode[EM_XHYS+:2] == 2'h0 && q.feature_control[FT_HYS+:2] == 2'h3
      |-> hyst == 6'h08) else $error("hysteresis map wrong");
endmodule : uart_enh_regs

// file: hdl/uart_enh_pkg.sv
// Purpose: Shared constants for the channel enhanced-feature register bank.
// Assumes: Wishbone byte addresses, one aligned 32-bit word per register.
// Notes: Data sits in the low byte; upper bits read as zero.
package uart_enh_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADR_DIV_LO = 8'h00;
   localparam logic [7:0] ADR_DIV_HI = 8'h04;
   localparam logic [7:0] ADR_DIV_FR = 8'h08;
   localparam logic [7:0] ADR_ALT_FN = 8'h0c;
   localparam logic [7:0] ADR_DEV_ID = 8'h10;
   localparam logic [7:0] ADR_DEV_RV = 8'h14;
   localparam logic [7:0] ADR_TRG = 8'h18;
   localparam logic [7:0] ADR_FCOUNT = 8'h1c;
   localparam logic [7:0] ADR_FEAT = 8'h20;
   localparam logic [7:0] ADR_SCRATCH = 8'h24;
   localparam logic [7:0] ADR_ENH_FEAT = 8'h28;
   localparam logic [7:0] ADR_LINE_CTL = 8'h2c;
   // Reset values, enhanced mode write mask and count access key.
   localparam logic [7:0] DIV_LO_RST = 8'h01;
   localparam logic [7:0] DIV_HI_RST = 8'h00;
   localparam logic [7:0] EMODE_RST = 8'h80;
   localparam logic [7:0] SCRATCH_RST = 8'hff;
   localparam logic [7:0] EMODE_WMASK = 8'hfb;
   localparam logic [7:0] FC_KEY = 8'hbf;
   // Feature control fields.
   localparam int FT_HYS = 0;
   localparam int FT_IRINV = 2;
   localparam int FT_R485 = 3;
   localparam int FT_TBL = 4;
   localparam int FT_SWAP = 6;
   localparam int FT_TSEL = 7;
   // Enhanced mode select fields.
   localparam int EM_CNT = 0;
   localparam int EM_INV = 3;
   localparam int EM_XHYS = 4;
   localparam int EM_LSRI = 6;
   localparam int EM_S16 = 7;
   // Alternate function fields, enhanced-enable bit position and table D code.
   localparam int AF_CW = 0;
   localparam int AF_MF = 1;
   localparam int ENH_BIT = 4;
   localparam logic [1:0] MF_OUT2 = 2'h0;
   localparam logic [1:0] MF_BAUD = 2'h1;
   localparam logic [1:0] MF_RECEIVE_READY_OUT = 2'h2;
   localparam logic [1:0] MF_RSVD = 2'h3;
   localparam logic [1:0] TBL_D = 2'h3;
   // Hysteresis in characters, indexed by {extended, basic}.
   localparam logic [5:0] HYST_TAB [16] = '{
      6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
      6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
endpackage : uart_enh_pkg

// file: bench/wb_host_model.sv
// Purpose: Host processor model issuing classic Wishbone cycles.
// Assumes: One request at a time; the bench timeout ends a hang.
// Notes: Released address and data lines show the inverse value.
`timescale 1ns/1ps
module wb_host_model (
   // Clock and answer.
   input wire logic clk_i,
   input wire logic ack_i,
   // Request.
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'hff;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // The request is held until ack is sampled, so any slave latency works.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'h1;
      dat_o <= {24'h0, d};
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~{24'h0, d};
   endtask : xfer
endmodule : wb_host_model

// file: bench/tb_uart_enhanced_feature_registers.sv
// Purpose: Self-checking bench for the enhanced-feature register bank.
// Assumes: Reads and write pulses are noted in a queue and checked on ack.
// Notes: A note with bit 32 set checks the peer write pulse against bit 0.
`timescale 1ns/1ps
module tb_uart_enhanced_feature_registers;
   import uart_enh_pkg::*;
   localparam logic [7:0] ID_V = 8'h3a;  // Arbitrary value.
   localparam logic [7:0] RV_V = 8'h07;  // Arbitrary value.
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic cyc_i, stb_i, we_i, ack_o, peer_we_o, sample16_o;
   logic [7:0] adr_i, peer_adr_o, peer_dat_o, rx_trig_o, tx_trig_o;
   logic [3:0] sel_i, div_frac_o;
   logic [31:0] dat_i, dat_o;
   logic [15:0] div_int_o;
   logic [1:0] trig_table_o;
   logic line_irq_o, tx_irq_o, rts_n_o, multi_function_out_o, rx_data_o;
   logic peer_we_i = 1'b0, err_into_fifo_i = 1'b0, err_at_holding_i = 1'b0;
   logic [7:0] peer_adr_i = 8'h0, peer_dat_i = 8'h0, rx_table_level_i = 8'h0;
   logic [6:0] rx_count_i = 7'h0, tx_count_i = 7'h0;
   logic status_read_i = 1'b0, tx_fifo_load_i = 1'b0, tx_shift_done_i = 1'b0;
   logic thr_empty_i = 1'b0, tsr_empty_i = 1'b0, bit_tick_i = 1'b0;
   logic auto_rts_en_i = 1'b0, rts_manual_n_i = 1'b1, rx_pin_i = 1'b0;
   logic user_output_two_i = 1'b0, baud_clock_i = 1'b0;
   logic receive_ready_i = 1'b0;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   logic [31:0] v;
   logic [2:0] src;
   integer seed = 32'hadb4;
   int num_errors = 0, n_compared = 0, cycles = 0, h;
   always #4 clk_i = ~clk_i;
   uart_enh_regs #(.DEV_ID_VAL(ID_V), .DEV_REV_VAL(RV_V)) uut (.*);
   wb_host_model host (.clk_i(clk_i), .ack_i(ack_o), .cyc_o(cyc_i),
      .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
      .dat_o(dat_i));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h, want %h", $time, s, e);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({25'h0, e});
      host.xfer(1'b0, a, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic p);
      exp_q.push_back({1'b1, 31'h0, p});
      host.xfer(1'b1, a, d);
   endtask : wr
   // Generous wait, since the input synchroniser needs several cycles.
   task automatic settle;
      repeat (6) @(posedge clk_i);
   endtask : settle
   task automatic rts(input int c, input logic e);
      rx_count_i <= 7'(c);
      settle();
      chk(32'(rts_n_o), 32'(e));
   endtask : rts
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
      if (ack_o === 1'b1) begin
         note = exp_q.pop_front();
         chk(note[32] ? 32'(peer_we_o) : dat_o, note[31:0]);
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(32'(sample16_o), 32'h1);
      rd(ADR_DIV_LO, 8'h01);
      rd(ADR_DIV_FR, 8'h00);
      rd(ADR_ALT_FN, 8'h00);
      rd(ADR_FEAT, 8'h00);
      rd(ADR_SCRATCH, 8'hff);
      rd(8'h3c, 8'h00);
      wr(ADR_DEV_ID, 8'h00, 1'b0);
      wr(ADR_DIV_LO, 8'h00, 1'b0);
      rd(ADR_DEV_ID, ID_V);
      rd(ADR_DEV_RV, RV_V);
      v = $random(seed);
      wr(ADR_DIV_LO, v[7:0], 1'b0);
      wr(ADR_DIV_HI, v[15:8], 1'b0);
      wr(ADR_SCRATCH, v[23:16], 1'b0);
      rd(ADR_SCRATCH, v[23:16]);
      chk(32'(div_int_o), 32'(v[15:0]));
      wr(ADR_DIV_FR, 8'ha7, 1'b0);
      rd(ADR_DIV_FR, 8'h00);
      wr(ADR_ENH_FEAT, 8'h10, 1'b0);
      wr(ADR_DIV_FR, 8'ha7, 1'b0);
      rd(ADR_DIV_FR, 8'ha7);
      chk(32'(div_frac_o), 32'h7);
      wr(ADR_ENH_FEAT, 8'h00, 1'b0);
      wr(ADR_DIV_FR, 8'h55, 1'b0);
      wr(ADR_ENH_FEAT, 8'h10, 1'b0);
      rd(ADR_DIV_FR, 8'ha7);
      wr(ADR_LINE_CTL, 8'h00, 1'b0);
      wr(ADR_ALT_FN, 8'hff, 1'b1);
      rd(ADR_ALT_FN, 8'h01);
      wr(ADR_DIV_LO, 8'h12, 1'b1);
      chk(32'(peer_adr_o), 32'(ADR_DIV_LO));
      chk(32'(peer_dat_o), 32'h12);
      for (int i = 0; i < 3; i++) begin
         wr(ADR_ALT_FN, 8'(i * 2), 1'b1);
         for (int k = 0; k < 2; k++) begin
            src = 3'(1 << i) ^ {3{k[0]}};
            {receive_ready_i, baud_clock_i, user_output_two_i} <= src;
            settle();
            chk(32'(multi_function_out_o), 32'(src[i]));
         end
      end
      wr(ADR_DIV_LO, 8'h12, 1'b0);
      peer_adr_i <= ADR_SCRATCH;
      peer_dat_i <= 8'h3c;
      peer_we_i <= 1'b1;
      @(posedge clk_i);
      peer_we_i <= 1'b0;
      peer_dat_i <= 8'hc3;
      rd(ADR_SCRATCH, 8'h3c);
      v = $random(seed);
      rx_count_i <= v[6:0];
      tx_count_i <= v[14:8];
      wr(ADR_FEAT, 8'h40, 1'b0);
      wr(ADR_SCRATCH, 8'h03, 1'b0);
      rd(ADR_SCRATCH, {1'b0, v[6:0]});
      rd(ADR_SCRATCH, {1'b0, v[14:8]});
      rd(ADR_SCRATCH, {1'b0, v[6:0]});
      chk(32'(sample16_o), 32'h0);
      wr(ADR_SCRATCH, 8'h81, 1'b0);
      rd(ADR_SCRATCH, {1'b0, v[14:8]});
      wr(ADR_SCRATCH, 8'h82, 1'b0);
      rd(ADR_SCRATCH, {1'b0, v[6:0]});
      chk(32'(sample16_o), 32'h1);
      wr(ADR_LINE_CTL, FC_KEY, 1'b0);
      rd(ADR_FCOUNT, {1'b0, v[6:0]});
      wr(ADR_FEAT, 8'hf0, 1'b0);
      rd(ADR_FCOUNT, {1'b0, v[14:8]});
      wr(ADR_TRG, 8'h2a, 1'b0);
      wr(ADR_FEAT, 8'h70, 1'b0);
      wr(ADR_TRG, 8'h15, 1'b0);
      chk(32'(tx_trig_o), 32'h2a);
      chk(32'(rx_trig_o), 32'h15);
      rd(ADR_TRG, 8'h00);
      wr(ADR_LINE_CTL, 8'h3f, 1'b0);
      rd(ADR_FCOUNT, 8'h00);
      err_at_holding_i <= 1'b1;
      settle();
      chk(32'(line_irq_o), 32'h1);
      err_at_holding_i <= 1'b0;
      wr(ADR_SCRATCH, 8'hc0, 1'b0);
      settle();
      chk(32'(line_irq_o), 32'h0);
      err_into_fifo_i <= 1'b1;
      @(posedge clk_i);
      err_into_fifo_i <= 1'b0;
      settle();
      chk(32'(line_irq_o), 32'h1);
      err_into_fifo_i <= 1'b1;
      status_read_i <= 1'b1;
      @(posedge clk_i);
      err_into_fifo_i <= 1'b0;
      status_read_i <= 1'b0;
      settle();
      chk(32'(line_irq_o), 32'h1);
      status_read_i <= 1'b1;
      @(posedge clk_i);
      status_read_i <= 1'b0;
      settle();
      chk(32'(line_irq_o), 32'h0);
      for (int j = 0; j < 4; j++) begin
         wr(ADR_FEAT, 8'(j * 16), 1'b0);
         settle();
         chk(32'(trig_table_o), 32'(j));
      end
      rd(ADR_SCRATCH, 8'h3c);
      auto_rts_en_i <= 1'b1;
      rts_manual_n_i <= 1'b0;
      rx_table_level_i <= 8'd40;
      rx_count_i <= 7'h0;
      for (int c = 0; c < 2; c++) begin
         wr(ADR_FEAT, c ? 8'h43 : 8'h41, 1'b0);
         wr(ADR_SCRATCH, c ? 8'h80 : 8'h90, 1'b0);
         h = c ? 8 : 16;
         rts(39 + h, 1'b0);
         rts(40 + h, 1'b1);
         rts(40 - h, 1'b1);
         rts(39 - h, 1'b0);
      end
      auto_rts_en_i <= 1'b0;
      thr_empty_i <= 1'b1;
      wr(ADR_FEAT, 8'h08, 1'b0);
      settle();
      chk(32'(tx_irq_o), 32'h0);
      chk(32'(rts_n_o), 32'h1);
      tx_fifo_load_i <= 1'b1;
      @(posedge clk_i);
      tx_fifo_load_i <= 1'b0;
      settle();
      chk(32'(rts_n_o), 32'h0);
      tx_shift_done_i <= 1'b1;
      @(posedge clk_i);
      tx_shift_done_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(rts_n_o), 32'h0);
      bit_tick_i <= 1'b1;
      @(posedge clk_i);
      bit_tick_i <= 1'b0;
      tsr_empty_i <= 1'b1;
      settle();
      chk(32'(rts_n_o), 32'h1);
      chk(32'(tx_irq_o), 32'h1);
      wr(ADR_FEAT, 8'h48, 1'b0);
      wr(ADR_SCRATCH, 8'h88, 1'b0);
      settle();
      chk(32'(rts_n_o), 32'h0);
      tsr_empty_i <= 1'b0;
      rx_pin_i <= 1'b1;
      wr(ADR_FEAT, 8'h00, 1'b0);
      settle();
      chk(32'(tx_irq_o), 32'h1);
      chk(32'(rx_data_o), 32'h1);
      wr(ADR_FEAT, 8'h04, 1'b0);
      settle();
      chk(32'(rx_data_o), 32'h0);
      wr(ADR_FEAT, 8'h07, 1'b0);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_FEAT, 8'h00);
      report_and_stop();
   end
endmodule : tb_uart_enhanced_feature_registers
